//--- rtl/lpts_pkg.sv
// Package with constants and types for the laser pulse trigger sequencer
package lpts_pkg;

    // Clock and sampling timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int SAMPLE_INTERVAL_NS = 20000;
    localparam int SAMPLE_INTERVAL_CYC = (SAMPLE_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SAMPLE_TICK_W = 10;
    localparam int SAMPLE_DEPTH = 256;
    localparam int SAMPLE_IDX_W = 8;
    localparam int MON_W = 16;
    localparam int TEMP_COUNT = 8;

    // Trigger source encodings
    localparam logic [1:0] SRC_INTERNAL = 2'h0;
    localparam logic [1:0] SRC_DIRECT = 2'h1;
    localparam logic [1:0] SRC_EDGE = 2'h2;
    localparam logic [1:0] SRC_SOFTWARE = 2'h3;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_WIDTH = 8'h04;
    localparam logic [7:0] ADDR_PAUSE = 8'h08;
    localparam logic [7:0] ADDR_COUNT = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_SAMP_NUM = 8'h14;
    localparam logic [7:0] ADDR_SAMP_SEL = 8'h18;
    localparam logic [7:0] ADDR_SAMP_CUR = 8'h1C;
    localparam logic [7:0] ADDR_SAMP_VOLT = 8'h20;
    localparam logic [7:0] ADDR_SAMP_CAP = 8'h24;
    localparam logic [7:0] ADDR_SAMP_PRE = 8'h28;
    localparam logic [7:0] ADDR_SAMP_MAIN = 8'h2C;
    localparam logic [7:0] ADDR_SUPPLY = 8'h30;
    localparam logic [7:0] ADDR_TEMP_BASE = 8'h40;
    localparam logic [7:0] ADDR_TEMP_LAST = 8'h5C;

    // Control field positions
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_POL_BIT = 2;
    localparam int CTRL_SWTRIG_BIT = 3;

    // Reset values
    localparam logic [1:0] RST_SRC = 2'h0;
    localparam logic RST_POL = 1'b1;
    localparam logic [31:0] RST_WIDTH = 32'h0000_0FA0;
    localparam logic [31:0] RST_PAUSE = 32'h0000_9C40;
    localparam logic [31:0] RST_COUNT = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    // Pulse generator states
    typedef enum logic [1:0] {
        GEN_IDLE = 2'b00,
        GEN_PAUSE = 2'b01,
        GEN_PULSE = 2'b10,
        GEN_DONE = 2'b11
    } lpts_gen_state_type;

    // One monitor sample set
    typedef struct packed {
        logic [15:0] load_current;
        logic [15:0] load_voltage;
        logic [15:0] cap_voltage;
        logic [15:0] pre_pulse_ctrl;
        logic [15:0] main_pulse_ctrl;
    } lpts_sample_type;

    // Avalon request from master
    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } lpts_avs_req_type;

endpackage

//--- rtl/lpts_top.sv
// Trigger sequencer, interlock logic, pulse sample buffer and register slave
//
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps

module lpts_top
    import lpts_pkg::*;
(
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Avalon-MM slave
    input wire lpts_avs_req_type avs_req,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Control pins
    input wire logic enable_pin,
    input wire logic interlock_pin,
    input wire logic trig_pin,
    // Monitor inputs
    input wire lpts_sample_type mon_sample,
    input wire logic [15:0] supply_voltage,
    input wire logic [TEMP_COUNT-1:0][15:0] temperature,
    // Driver outputs
    output logic pulse_out,
    output logic trig_out,
    output logic charge_en,
    output logic discharge,
    output logic error_out
);

    // Edge detect on synchronised level
    function automatic logic edge_seen(input logic now_v, input logic old_v, input logic rising);
        edge_seen = rising ? (now_v & ~old_v) : (~now_v & old_v);
    endfunction

    // Synchronisers
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [2:0] prev_reg;
    logic enable_s;
    logic interlock_s;
    logic trig_s;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            prev_reg <= 3'h0;
        end else if (clk_en) begin
            sync1_reg <= {trig_pin, interlock_pin, enable_pin};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    assign enable_s = sync2_reg[0];
    assign interlock_s = sync2_reg[1];
    assign trig_s = sync2_reg[2];

    // Configuration registers
    logic [1:0] src_reg;
    logic pol_reg;
    logic [31:0] width_reg;
    logic [31:0] pause_reg;
    logic [31:0] count_reg;
    logic [SAMPLE_IDX_W-1:0] samp_sel_reg;
    logic sw_trig_reg;
    logic ack_reg;
    logic wr_take;
    logic rd_take;

    assign rd_take = avs_req.read & ~ack_reg;
    assign wr_take = avs_req.write & ack_reg;
    assign avs_waitrequest = (avs_req.read | avs_req.write) & ~ack_reg;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
        end else if (clk_en) begin
            ack_reg <= (avs_req.read | avs_req.write) & ~ack_reg;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            src_reg <= RST_SRC;
            pol_reg <= RST_POL;
            width_reg <= RST_WIDTH;
            pause_reg <= RST_PAUSE;
            count_reg <= RST_COUNT;
            samp_sel_reg <= '0;
            sw_trig_reg <= 1'b0;
        end else if (clk_en) begin
            sw_trig_reg <= 1'b0;
            if (wr_take && avs_req.byteenable[0]) begin
                case (avs_req.address)
                    ADDR_CTRL: begin
                        if (!enable_s) begin
                            src_reg <= avs_req.writedata[CTRL_SRC_LSB +: 2];
                            pol_reg <= avs_req.writedata[CTRL_POL_BIT];
                        end
                        sw_trig_reg <= avs_req.writedata[CTRL_SWTRIG_BIT];
                    end
                    ADDR_WIDTH: width_reg <= avs_req.writedata;
                    ADDR_PAUSE: pause_reg <= avs_req.writedata;
                    ADDR_COUNT: count_reg <= avs_req.writedata;
                    ADDR_SAMP_SEL: samp_sel_reg <= avs_req.writedata[SAMPLE_IDX_W-1:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // Interlock and error sequencing
    logic error_reg;
    logic charge_reg;
    logic error_set;
    logic output_ok;

    assign error_set = (edge_seen(enable_s, prev_reg[0], 1'b1) & ~interlock_s)
        | (edge_seen(interlock_s, prev_reg[1], 1'b0) & enable_s);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            error_reg <= 1'b0;
        end else if (clk_en) begin
            if (error_set) begin
                error_reg <= 1'b1;
            end else if (!enable_s) begin
                error_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            charge_reg <= 1'b0;
        end else if (clk_en) begin
            if (!interlock_s || error_set || error_reg) begin
                charge_reg <= 1'b0;
            end else if (edge_seen(interlock_s, prev_reg[1], 1'b1) && !enable_s) begin
                charge_reg <= 1'b1;
            end
        end
    end

    assign output_ok = enable_s & interlock_s & charge_reg & ~error_reg & ~error_set;

    // Burst pulse generator
    lpts_gen_state_type gen_state_reg;
    logic [31:0] gen_cnt_reg;
    logic [31:0] remain_reg;
    logic gen_run;
    logic launch;
    logic last_pulse;

    assign gen_run = output_ok & (src_reg != SRC_DIRECT);
    assign launch = (src_reg == SRC_EDGE) ? edge_seen(trig_s, prev_reg[2], pol_reg)
        : (src_reg == SRC_SOFTWARE) & sw_trig_reg;
    assign last_pulse = (count_reg != 32'h0000_0000) && (remain_reg <= 32'h0000_0001);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gen_state_reg <= GEN_IDLE;
            gen_cnt_reg <= 32'h0000_0000;
            remain_reg <= 32'h0000_0000;
        end else if (clk_en) begin
            if (!gen_run) begin
                gen_state_reg <= GEN_IDLE;
            end else begin
                case (gen_state_reg)
                    GEN_IDLE: begin
                        remain_reg <= count_reg;
                        if (src_reg == SRC_INTERNAL) begin
                            gen_state_reg <= GEN_PAUSE;
                            gen_cnt_reg <= pause_reg;
                        end else if (launch) begin
                            gen_state_reg <= GEN_PULSE;
                            gen_cnt_reg <= width_reg;
                        end
                    end
                    GEN_PAUSE: begin
                        if (gen_cnt_reg <= 32'h0000_0001) begin
                            gen_state_reg <= GEN_PULSE;
                            gen_cnt_reg <= width_reg;
                        end else begin
                            gen_cnt_reg <= gen_cnt_reg - 32'h0000_0001;
                        end
                    end
                    GEN_PULSE: begin
                        if (gen_cnt_reg > 32'h0000_0001) begin
                            gen_cnt_reg <= gen_cnt_reg - 32'h0000_0001;
                        end else if (last_pulse) begin
                            gen_state_reg <= (src_reg == SRC_INTERNAL) ? GEN_DONE : GEN_IDLE;
                        end else begin
                            gen_state_reg <= GEN_PAUSE;
                            gen_cnt_reg <= pause_reg;
                            remain_reg <= remain_reg - 32'h0000_0001;
                        end
                    end
                    GEN_DONE: begin
                        gen_state_reg <= GEN_DONE;
                    end
                    default: begin
                        gen_state_reg <= GEN_IDLE;
                    end
                endcase
            end
        end
    end

    // Output stage
    logic pulse_reg;
    logic pulse_d_reg;
    logic direct_active;

    assign direct_active = pol_reg ? trig_s : ~trig_s;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pulse_reg <= 1'b0;
            pulse_d_reg <= 1'b0;
        end else if (clk_en) begin
            if (src_reg == SRC_DIRECT) begin
                pulse_reg <= output_ok & direct_active;
            end else begin
                pulse_reg <= gen_run & (gen_state_reg == GEN_PULSE);
            end
            pulse_d_reg <= pulse_reg;
        end
    end

    assign pulse_out = pulse_reg;
    assign trig_out = pulse_reg;
    assign charge_en = charge_reg;
    assign discharge = ~interlock_s | error_reg;
    assign error_out = error_reg;

    // Per-pulse sample buffer
    lpts_sample_type samp_mem [SAMPLE_DEPTH];
    logic [SAMPLE_IDX_W:0] samp_num_reg;
    logic [SAMPLE_TICK_W-1:0] tick_reg;
    logic capture;

    assign capture = pulse_reg & pulse_d_reg & (tick_reg == '0) & (samp_num_reg < (SAMPLE_IDX_W + 1)'(SAMPLE_DEPTH));

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            samp_num_reg <= '0;
            tick_reg <= '0;
        end else if (clk_en) begin
            if (pulse_reg && !pulse_d_reg) begin
                samp_num_reg <= '0;
                tick_reg <= '0;
            end else if (pulse_reg) begin
                if (capture) begin
                    samp_num_reg <= samp_num_reg + 1'b1;
                end
                if (tick_reg == SAMPLE_TICK_W'(SAMPLE_INTERVAL_CYC - 1)) begin
                    tick_reg <= '0;
                end else begin
                    tick_reg <= tick_reg + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (clk_en && capture) begin
            samp_mem[samp_num_reg[SAMPLE_IDX_W-1:0]] <= mon_sample;
        end
    end

    // Read data path
    lpts_sample_type sel_sample;
    logic [31:0] rd_next;
    logic [31:0] status_word;

    assign sel_sample = samp_mem[samp_sel_reg];
    assign status_word = {24'h00_0000, (gen_state_reg == GEN_DONE), pulse_reg, charge_reg, error_reg,
        discharge, trig_s, interlock_s, enable_s};

    always_comb begin
        rd_next = UNMAPPED_DATA;
        case (avs_req.address)
            ADDR_CTRL: rd_next = {29'h0000_0000, pol_reg, src_reg};
            ADDR_WIDTH: rd_next = width_reg;
            ADDR_PAUSE: rd_next = pause_reg;
            ADDR_COUNT: rd_next = count_reg;
            ADDR_STATUS: rd_next = status_word;
            ADDR_SAMP_NUM: rd_next = {23'h00_0000, samp_num_reg};
            ADDR_SAMP_SEL: rd_next = {24'h00_0000, samp_sel_reg};
            ADDR_SAMP_CUR: rd_next = {16'h0000, sel_sample.load_current};
            ADDR_SAMP_VOLT: rd_next = {16'h0000, sel_sample.load_voltage};
            ADDR_SAMP_CAP: rd_next = {16'h0000, sel_sample.cap_voltage};
            ADDR_SAMP_PRE: rd_next = {16'h0000, sel_sample.pre_pulse_ctrl};
            ADDR_SAMP_MAIN: rd_next = {16'h0000, sel_sample.main_pulse_ctrl};
            ADDR_SUPPLY: rd_next = {16'h0000, supply_voltage};
            default: begin
                if (avs_req.address >= ADDR_TEMP_BASE && avs_req.address <= ADDR_TEMP_LAST
                    && avs_req.address[1:0] == 2'h0) begin
                    rd_next = {16'h0000, temperature[avs_req.address[4:2]]};
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (clk_en && rd_take) begin
            avs_readdata <= rd_next;
        end
    end

endmodule

//--- sim/lpts_monitor.sv
// Checker for pin sequencing and bus handshake of the trigger sequencer
`timescale 1ns/1ps

module lpts_monitor
    import lpts_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Bus
    input wire lpts_avs_req_type avs_req,
    input wire logic avs_waitrequest,
    // Control pins
    input wire logic enable_pin,
    input wire logic interlock_pin,
    // Driver outputs
    input wire logic pulse_out,
    input wire logic trig_out,
    input wire logic charge_en,
    input wire logic discharge,
    input wire logic error_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Bus request and its single wait cycle
    sequence s_req_start;
        $rose(avs_req.read || avs_req.write);
    endsequence
    sequence s_one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    // Safe state after interlock loss
    sequence s_safe;
        ##[2:5] (error_out && !pulse_out && discharge);
    endsequence

    AST_BUS_ONE_WAIT: assert property (s_req_start |-> s_one_wait)
        else $error("bus answer not after one wait cycle");
    AST_TRIG_COPY: assert property (trig_out == pulse_out)
        else $error("trigger output differs from pulse");
    AST_DROP_SAFE: assert property ($fell(interlock_pin) && enable_pin && $past(enable_pin, 4) |-> s_safe)
        else $error("interlock loss not handled");
    AST_ERR_NO_PULSE: assert property (error_out [*2] |=> !pulse_out)
        else $error("pulse during error");
    AST_ERR_CLEAR_LOW: assert property ($fell(error_out) |-> !$past(enable_pin, 3))
        else $error("error cleared while enabled");
    AST_CHARGE_IL: assert property ($rose(charge_en) |-> interlock_pin && !error_out)
        else $error("charging without interlock");
    AST_EN_FIRST: assert property ($rose(enable_pin) && !interlock_pin |-> ##[2:5] (error_out && !charge_en))
        else $error("enable before interlock not flagged");
    AST_DISABLED_QUIET: assert property (!enable_pin [*5] |-> !pulse_out)
        else $error("pulse while disabled");
    AST_DISCH_IL: assert property (!interlock_pin [*3] |-> discharge)
        else $error("no discharge without interlock");
endmodule

bind lpts_top lpts_monitor chk (.ref_clk(ref_clk), .rst(rst), .avs_req(avs_req),
    .avs_waitrequest(avs_waitrequest), .enable_pin(enable_pin), .interlock_pin(interlock_pin),
    .pulse_out(pulse_out), .trig_out(trig_out), .charge_en(charge_en), .discharge(discharge),
    .error_out(error_out));

//--- sim/lpts_pins_model.sv
// Model of host control pins, external trigger source and monitor front end
`timescale 1ns/1ps

module lpts_pins_model
    import lpts_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Observed pulse
    input wire logic pulse_out,
    // Control pins
    output logic enable_pin,
    output logic interlock_pin,
    output logic trig_pin,
    // Monitor values
    output lpts_sample_type mon_sample,
    output logic [15:0] supply_voltage,
    output logic [TEMP_COUNT-1:0][15:0] temperature
);
    logic [15:0] pulse_idx;
    logic pulse_prev;

    initial begin
        enable_pin = 1'b0;
        interlock_pin = 1'b0;
        trig_pin = 1'b0;
    end

    // Pin levels change just after an edge, then hold
    task automatic drive(input logic en, input logic il, input logic tg, input int hold);
        @(posedge ref_clk);
        enable_pin <= en;
        interlock_pin <= il;
        trig_pin <= tg;
        repeat (hold) @(posedge ref_clk);
    endtask

    // Monitor values step once per finished pulse
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pulse_idx <= 16'h0000;
            pulse_prev <= 1'b0;
        end else begin
            pulse_prev <= pulse_out;
            if (pulse_prev && !pulse_out) begin
                pulse_idx <= pulse_idx + 16'h0001;
            end
        end
    end

    assign mon_sample = {16'h1000 + pulse_idx, 16'h2000 + pulse_idx, 16'h3000 + pulse_idx,
        16'h4000 + pulse_idx, 16'h5000 + pulse_idx};
    assign supply_voltage = 16'h0BB8;

    always_comb begin
        for (int i = 0; i < TEMP_COUNT; i++) begin
            temperature[i] = 16'h0100 + 16'(i);
        end
    end
endmodule

//--- sim/lpts_top_tb.sv
// Self-checking bench for the trigger sequencer
`timescale 1ns/1ps

module lpts_top_tb;
    import lpts_pkg::*;

    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    lpts_avs_req_type avs_req = '0;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, enable_pin, interlock_pin, trig_pin, pl = 1'b0;
    lpts_sample_type mon_sample;
    logic [15:0] supply_voltage;
    logic [TEMP_COUNT-1:0][15:0] temperature;
    logic pulse_out, trig_out, charge_en, discharge, error_out;
    int err_total = 0, compares = 0, cyc = 0, pcount = 0, first_rise = 0, hrun = 0, hlen = 0, t0 = 0;

    lpts_top dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .avs_req(avs_req),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .enable_pin(enable_pin),
        .interlock_pin(interlock_pin), .trig_pin(trig_pin), .mon_sample(mon_sample),
        .supply_voltage(supply_voltage), .temperature(temperature), .pulse_out(pulse_out),
        .trig_out(trig_out), .charge_en(charge_en), .discharge(discharge), .error_out(error_out));
    lpts_pins_model pins (.ref_clk(ref_clk), .rst(rst), .pulse_out(pulse_out), .enable_pin(enable_pin),
        .interlock_pin(interlock_pin), .trig_pin(trig_pin), .mon_sample(mon_sample),
        .supply_voltage(supply_voltage), .temperature(temperature));

    always #12.5 ref_clk = ~ref_clk;

    // Pulse counter, width and timeout
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        pl <= pulse_out;
        if (pulse_out && !pl && pcount == 0) first_rise <= cyc;
        if (pulse_out && !pl) pcount <= pcount + 1;
        hrun <= pulse_out ? hrun + 1 : 0;
        if (!pulse_out && pl) hlen <= hrun;
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            err_total++;
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_req <= '{address: a, read: !wr, write: wr, writedata: d, byteenable: 4'hF};
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_req <= '0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        check(q, e);
    endtask

    task automatic t_regs();
        rdchk(ADDR_CTRL, 32'h0000_0004);
        rdchk(ADDR_WIDTH, RST_WIDTH);
        rdchk(ADDR_PAUSE, RST_PAUSE);
        rdchk(ADDR_COUNT, RST_COUNT);
        rdchk(8'h3C, UNMAPPED_DATA);
        rdchk(ADDR_SUPPLY, 32'h0000_0BB8);
        for (int i = 0; i < TEMP_COUNT; i++) begin
            rdchk(ADDR_TEMP_BASE + 8'(4 * i), 32'h0000_0100 + 32'(i));
        end
        bus(1'b1, ADDR_WIDTH, 32'h0000_0003);
        bus(1'b1, ADDR_PAUSE, 32'h0000_0005);
        bus(1'b1, ADDR_COUNT, 32'h0000_0002);
        rdchk(ADDR_WIDTH, 32'h0000_0003);
    endtask

    task automatic t_order();
        pins.drive(1'b1, 1'b0, 1'b0, 8);
        check(32'(error_out), 32'h0000_0001);
        check(32'(charge_en), 32'h0000_0000);
        pins.drive(1'b0, 1'b0, 1'b0, 8);
        check(32'(error_out), 32'h0000_0000);
    endtask

    task automatic t_internal();
        pins.drive(1'b0, 1'b1, 1'b0, 8);
        check(32'(charge_en), 32'h0000_0001);
        pcount = 0;
        pins.drive(1'b1, 1'b1, 1'b0, 0);
        t0 = cyc;
        repeat (40) @(posedge ref_clk);
        check(32'(pcount), 32'h0000_0002);
        check(32'(hlen), 32'h0000_0003);
        check(32'((first_rise - t0) inside {[5:14]}), 32'h0000_0001);
        pins.drive(1'b0, 1'b1, 1'b0, 6);
        bus(1'b1, ADDR_SAMP_SEL, 32'h0000_0000);
        rdchk(ADDR_SAMP_NUM, 32'h0000_0001);
        rdchk(ADDR_SAMP_CUR, 32'h0000_1001);
        rdchk(ADDR_SAMP_CAP, 32'h0000_3001);
    endtask

    // Long direct pulse spans two sample intervals
    task automatic t_direct();
        bus(1'b1, ADDR_CTRL, 32'h0000_0001);
        pins.drive(1'b0, 1'b1, 1'b1, 4);
        pcount = 0;
        pins.drive(1'b1, 1'b1, 1'b1, 6);
        bus(1'b1, ADDR_CTRL, 32'h0000_0002);
        rdchk(ADDR_CTRL, 32'h0000_0001);
        pins.drive(1'b1, 1'b1, 1'b0, 900);
        pins.drive(1'b1, 1'b1, 1'b1, 8);
        check(32'(pcount), 32'h0000_0001);
        check(32'(hlen), 32'h0000_0385);
        rdchk(ADDR_SAMP_NUM, 32'h0000_0002);
        bus(1'b1, ADDR_SAMP_SEL, 32'h0000_0001);
        rdchk(ADDR_SAMP_VOLT, 32'h0000_2002);
        pins.drive(1'b0, 1'b1, 1'b1, 6);
    endtask

    task automatic t_edge();
        bus(1'b1, ADDR_CTRL, 32'h0000_0006);
        bus(1'b1, ADDR_COUNT, 32'h0000_0001);
        pcount = 0;
        pins.drive(1'b1, 1'b1, 1'b0, 8);
        check(32'(pcount), 32'h0000_0000);
        pins.drive(1'b1, 1'b1, 1'b1, 25);
        check(32'(pcount), 32'h0000_0001);
        pins.drive(1'b1, 1'b1, 1'b0, 25);
        check(32'(pcount), 32'h0000_0001);
        check(32'(hlen), 32'h0000_0003);
        pins.drive(1'b0, 1'b1, 1'b0, 6);
        bus(1'b1, ADDR_CTRL, 32'h0000_0002);
        pcount = 0;
        pins.drive(1'b1, 1'b1, 1'b1, 25);
        check(32'(pcount), 32'h0000_0000);
        pins.drive(1'b1, 1'b1, 1'b0, 25);
        check(32'(pcount), 32'h0000_0001);
        pins.drive(1'b0, 1'b1, 1'b0, 6);
    endtask

    task automatic t_soft_drop();
        bus(1'b1, ADDR_CTRL, 32'h0000_0003);
        bus(1'b1, ADDR_COUNT, 32'h0000_0000);
        pcount = 0;
        pins.drive(1'b1, 1'b1, 1'b0, 8);
        check(32'(pcount), 32'h0000_0000);
        bus(1'b1, ADDR_CTRL, 32'h0000_000B);
        repeat (30) @(posedge ref_clk);
        check(32'(pcount >= 2), 32'h0000_0001);
        pins.drive(1'b1, 1'b0, 1'b0, 8);
        check(32'(error_out), 32'h0000_0001);
        check(32'(discharge), 32'h0000_0001);
        check(32'(pulse_out), 32'h0000_0000);
        rdchk(ADDR_STATUS, 32'h0000_0019);
        pins.drive(1'b0, 1'b0, 1'b0, 8);
        check(32'(error_out), 32'h0000_0000);
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_order();
        t_internal();
        t_direct();
        t_edge();
        t_soft_drop();
        wrap_up();
    end
endmodule
